/* File: rtl/serial_to_parallel_latch.sv */
// serial-in shift register feeding a storage register through a two-entry buffer
`timescale 1ns/100ps
module serial_to_parallel_latch
    import sipo_latch_pkg::*;
#(
    parameter int unsigned WIDTH = STAGE_COUNT
)
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             serial_in,
    input  wire logic             shift_clock,
    input  wire logic             store_clock,
    input  wire logic             shift_clear_n,
    input  wire logic             store_clear_n,
    input  wire logic             parallel_ready,
    output logic [WIDTH-1:0]      parallel_out,
    output logic                  parallel_valid,
    output logic                  cascade_out,
    output logic                  store_ready
);

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************

    logic serial_lvl;
    logic shift_rise;
    logic store_rise;
    logic shift_clr_lvl_n;
    logic store_clr_lvl_n;

    // all five pins come from the host's domain and pass two flops each;
    // equal depth keeps serial data aligned with the shift clock edge
    // limitation: the clears pass the same two flops, so they land about three
    // clk cycles after the pin falls, and a clear shorter than one clk period
    // may be missed; link clock phases need the same one-period minimum
    pin_sync_rise u_sync_serial
    (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (serial_in),
        .level (serial_lvl),
        .rise  ()
    );

    pin_sync_rise u_sync_shift_clk
    (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (shift_clock),
        .level (),
        .rise  (shift_rise)
    );

    pin_sync_rise u_sync_store_clk
    (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (store_clock),
        .level (),
        .rise  (store_rise)
    );

    pin_sync_rise u_sync_shift_clr
    (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (shift_clear_n),
        .level (shift_clr_lvl_n),
        .rise  ()
    );

    pin_sync_rise u_sync_store_clr
    (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (store_clear_n),
        .level (store_clr_lvl_n),
        .rise  ()
    );

    // ****************************************************************
    // shift register
    // ****************************************************************

    logic [WIDTH-1:0] shift_reg;
    logic [WIDTH-1:0] shift_next;
    logic [WIDTH-1:0] shifted;

    // serial input enters stage zero, every stage moves one toward the last
    assign shifted = {shift_reg[WIDTH-2:0], serial_lvl};

    // clear wins over a coincident clock edge and leaves storage alone
    // a shift edge seen during a clear is dropped, not held over to the release
    assign shift_next = !shift_clr_lvl_n ? SHIFT_RESET
                      : shift_rise       ? shifted
                      :                    shift_reg;

    // eight stages, moved only on a shift clock rise
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            shift_reg <= SHIFT_RESET;
        else
            shift_reg <= shift_next;
    end

    // last stage goes out for chaining into the next device's serial input
    assign cascade_out = shift_reg[WIDTH-1];

    // ****************************************************************
    // two-entry buffer between shift and storage registers
    // ****************************************************************

    logic [WIDTH-1:0] buf_mem [BUF_DEPTH];
    logic [WIDTH-1:0] slot0_next;
    logic [WIDTH-1:0] slot1_next;
    logic             wr_ptr_reg;
    logic             rd_ptr_reg;
    logic [1:0]       fill_reg;
    logic [1:0]       fill_next;
    logic             buf_push;
    logic             buf_pop;
    logic             buf_empty;
    logic             buf_full;

    // a store rise is accepted only when there is room; a refused rise is lost,
    // and store_ready tells the host to hold off its next storage pulse
    assign buf_full    = (fill_reg == FILL_FULL);
    assign buf_empty   = (fill_reg == FILL_RESET);
    assign store_ready = !buf_full && store_clr_lvl_n;
    // snapshot is the shift register before this cycle's shift: with both clocks
    // tied the rises coincide and storage lags the shift register by one shift
    assign buf_push    = store_rise && store_ready;
    assign buf_pop     = !buf_empty && parallel_ready;

    // fill count: push and pop in the same cycle cancel out
    // push needs room and pop needs a word, so the count never leaves 0..2
    assign fill_next = !store_clr_lvl_n    ? FILL_RESET
                     : (buf_push & !buf_pop) ? fill_reg + 2'h1
                     : (!buf_push & buf_pop) ? fill_reg - 2'h1
                     :                        fill_reg;

    // pointers and count; storage clear also flushes words still in flight
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_reg <= PTR_RESET;
            rd_ptr_reg <= PTR_RESET;
            fill_reg   <= FILL_RESET;
        end
        else if (!store_clr_lvl_n)
        begin
            wr_ptr_reg <= PTR_RESET;
            rd_ptr_reg <= PTR_RESET;
            fill_reg   <= FILL_RESET;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_reg ^ buf_push;
            rd_ptr_reg <= rd_ptr_reg ^ buf_pop;
            fill_reg   <= fill_next;
        end
    end

    // each slot reloads itself unless this cycle's push is aimed at it
    assign slot0_next = (buf_push && !wr_ptr_reg) ? shift_reg : buf_mem[0];
    assign slot1_next = (buf_push &&  wr_ptr_reg) ? shift_reg : buf_mem[1];

    // buffer words; the reset keeps the read side free of unknown values
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            buf_mem[0] <= STORE_RESET;
            buf_mem[1] <= STORE_RESET;
        end
        else
        begin
            buf_mem[0] <= slot0_next;
            buf_mem[1] <= slot1_next;
        end
    end

    // ****************************************************************
    // storage register and parallel outputs
    // ****************************************************************

    logic [WIDTH-1:0] store_reg;
    logic [WIDTH-1:0] store_next;
    logic             valid_reg;
    logic             valid_next;

    // storage takes a buffered word when the receiver is ready for it;
    // clear overrides the load and never touches the shift stages
    assign store_next = !store_clr_lvl_n ? STORE_RESET
                      : buf_pop          ? buf_mem[rd_ptr_reg]
                      :                    store_reg;

    // one-cycle marker that a new word has just reached the outputs
    assign valid_next = store_clr_lvl_n && buf_pop;

    // storage bits, each held until the next load or clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            store_reg <= STORE_RESET;
            valid_reg <= SYNC_RESET;
        end
        else
        begin
            store_reg <= store_next;
            valid_reg <= valid_next;
        end
    end

    // each storage bit drives one parallel output continuously
    assign parallel_out   = store_reg;
    assign parallel_valid = valid_reg;

endmodule

/* File: inc/sipo_latch_pkg.sv */
// constants shared by the serial-to-parallel latch and its input synchroniser
// Operation
// - eight shift stages feed an eight-bit storage register
// - every storage bit drives its own parallel output at all times
// - shift and storage clocks are separate inputs, both rising-edge active
// - with both clocks tied, storage takes the pre-shift contents
// - low shift clear forces all eight shift stages to zero
// - low storage clear forces storage bits and parallel outputs to zero
// - each clear overrides its clock and touches only its own register; storage clear also flushes the two-entry buffer
// - cascade output carries the last shift stage for chaining
package sipo_latch_pkg;

    // ****************************************************************
    // widths and depths
    // ****************************************************************
    localparam int unsigned STAGE_COUNT = 8;
    localparam int unsigned BUF_DEPTH   = 2;
    localparam int unsigned SYNC_STAGES = 2;

    // ****************************************************************
    // values after reset
    // ****************************************************************
    localparam logic [STAGE_COUNT-1:0] SHIFT_RESET = 8'h00;
    localparam logic [STAGE_COUNT-1:0] STORE_RESET = 8'h00;
    localparam logic                   SYNC_RESET  = 1'h0;

    // ****************************************************************
    // buffer pointer and fill layout
    // ****************************************************************
    localparam logic       PTR_RESET  = 1'h0;
    localparam logic [1:0] FILL_RESET = 2'h0;
    localparam logic [1:0] FILL_FULL  = 2'h2;

endpackage

/* File: rtl/pin_sync_rise.sv */
// two-flop synchroniser for one pin, with a rising-edge pulse behind it
`timescale 1ns/100ps
module pin_sync_rise
    import sipo_latch_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);

    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // the first flop is read only by the second; edges are taken after it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= SYNC_RESET;
            sync_reg <= SYNC_RESET;
            last_reg <= SYNC_RESET;
        end
        else
        begin
            meta_reg <= pin;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // level and one-cycle pulse on each low-to-high change
    assign level = sync_reg;
    assign rise  = sync_reg & ~last_reg;

endmodule

/* File: dv/sipo_host_model.sv */
// host model driving the latch pins from the system clock
`timescale 1ns/100ps
module sipo_host_model
(
    input  wire logic clk,
    output logic      serial_in,
    output logic      shift_clock,
    output logic      store_clock,
    output logic      shift_clear_n,
    output logic      store_clear_n
);
    // ****
    // pin sequences
    // ****
    // link clocks rest low between frames; half period is four clk cycles
    initial
    begin
        serial_in     = 1'b0;
        shift_clock   = 1'b0;
        store_clock   = 1'b0;
        shift_clear_n = 1'b1;
        store_clear_n = 1'b1;
    end
    task automatic half;
        repeat (4) @(posedge clk);
    endtask
    // one 200 ns link period; data moves mid-way through the low phase,
    // well clear of either clock edge
    task automatic pulse(input logic b, input logic sh, input logic st);
        serial_in <= b;
        repeat (2) @(posedge clk);
        shift_clock <= sh;
        store_clock <= st;
        half();
        shift_clock <= 1'b0;
        store_clock <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    // first bit first, one word per device, then a single storage pulse
    task automatic send_word(input logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            pulse(d[i], 1'b1, 1'b0);
        pulse(1'b0, 1'b0, 1'b1);
    endtask
    // both clear pins are owned here, so the bench never drives them itself
    task automatic set_clears(input logic shift_n, input logic store_n);
        shift_clear_n <= shift_n;
        store_clear_n <= store_n;
    endtask
endmodule

/* File: dv/sipo_latch_checker.sv */
// concurrent checks on the latch ports
`timescale 1ns/100ps
module sipo_latch_checker
    import sipo_latch_pkg::*;
#(
    parameter int unsigned WIDTH = STAGE_COUNT
)
(
    input wire logic             clk,
    input wire logic             rst_n,
    input wire logic             serial_in,
    input wire logic             shift_clock,
    input wire logic             store_clock,
    input wire logic             shift_clear_n,
    input wire logic             store_clear_n,
    input wire logic             parallel_ready,
    input wire logic [WIDTH-1:0] parallel_out,
    input wire logic             parallel_valid,
    input wire logic             cascade_out,
    input wire logic             store_ready
);
    // ****
    // checks
    // ****
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // four samples cover two sync flops and the register edge
    sequence store_clr_s;
        !store_clear_n [*4];
    endsequence
    sequence store_rise_s;
        $rose(store_clock) && store_clear_n && store_ready;
    endsequence
    a_reset_zero: assert property (disable iff (1'b0) !rst_n |-> !parallel_out && !cascade_out)
        else $error("outputs not zero in reset");
    a_store_clear: assert property (store_clr_s |-> !parallel_out && !parallel_valid)
        else $error("storage not cleared");
    a_clear_blocks: assert property (store_clr_s |-> !store_ready)
        else $error("store accepted during clear");
    a_shift_clear: assert property (!shift_clear_n [*4] |-> !cascade_out)
        else $error("shift stages not cleared");
    a_cascade_quiet: assert property ((shift_clear_n && !shift_clock) [*6] |-> $stable(cascade_out))
        else $error("cascade moved without shift edge");
    a_out_quiet: assert property (store_clear_n [*5] ##1 !parallel_valid |-> $stable(parallel_out))
        else $error("outputs moved without load");
    a_valid_ready: assert property (parallel_valid |-> $past(parallel_ready))
        else $error("word given while stalled");
    a_store_latency: assert property (store_rise_s |-> (##[4:6] parallel_valid) or (##[1:6] !parallel_ready))
        else $error("stored word late");
endmodule

bind serial_to_parallel_latch sipo_latch_checker #(.WIDTH(WIDTH)) sipo_latch_checker_inst (
    .clk(clk), .rst_n(rst_n), .serial_in(serial_in), .shift_clock(shift_clock),
    .store_clock(store_clock), .shift_clear_n(shift_clear_n), .store_clear_n(store_clear_n),
    .parallel_ready(parallel_ready), .parallel_out(parallel_out),
    .parallel_valid(parallel_valid), .cascade_out(cascade_out), .store_ready(store_ready));

/* File: dv/tb.sv */
// self-checking bench for the serial-to-parallel latch
`timescale 1ns/100ps
module tb;
    logic       clk;
    logic       rst_n;
    logic       parallel_ready;
    logic       serial_in;
    logic       shift_clock;
    logic       store_clock;
    logic       shift_clear_n;
    logic       store_clear_n;
    logic [7:0] parallel_out;
    logic       parallel_valid;
    logic       cascade_out;
    logic       store_ready;
    logic [7:0] words = 8'h00;
    int         err_count = 0;
    int         samples_checked = 0;
    int         cycles = 0;

    sipo_host_model sipo_host_model_inst (.clk(clk), .serial_in(serial_in),
        .shift_clock(shift_clock), .store_clock(store_clock),
        .shift_clear_n(shift_clear_n), .store_clear_n(store_clear_n));
    serial_to_parallel_latch serial_to_parallel_latch_inst (.clk(clk), .rst_n(rst_n),
        .serial_in(serial_in), .shift_clock(shift_clock), .store_clock(store_clock),
        .shift_clear_n(shift_clear_n), .store_clear_n(store_clear_n),
        .parallel_ready(parallel_ready), .parallel_out(parallel_out),
        .parallel_valid(parallel_valid), .cascade_out(cascade_out), .store_ready(store_ready));

    // ****
    // clock, word count and hang guard
    // ****
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // the guard sits far above the 178 cycles that reset and the tests take
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (parallel_valid === 1'b1)
            words <= words + 8'h01;
        if (cycles == 4000)
        begin
            err_count++;
            end_sim();
        end
    end
    task automatic check(input logic [7:0] act, input logic [7:0] exp);
        samples_checked++;
        if (act !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    // ****
    // scenarios
    // ****
    task automatic test_load;
        sipo_host_model_inst.send_word(8'hA5);
        check(parallel_out, 8'hA5);
        check({7'h00, cascade_out}, 8'h01);
        check(words, 8'h01);
        $display("test_load done");
    endtask
    // tied clocks: storage takes the contents from before the same edge
    task automatic test_tied;
        sipo_host_model_inst.pulse(1'b0, 1'b1, 1'b1);
        check(parallel_out, 8'hA5);
        sipo_host_model_inst.pulse(1'b1, 1'b1, 1'b1);
        check(parallel_out, 8'h4A);
        check({7'h00, cascade_out}, 8'h01);
        $display("test_tied done");
    endtask
    // third store is refused while two words wait in the buffer
    task automatic test_stall;
        parallel_ready <= 1'b0;
        repeat (3) sipo_host_model_inst.pulse(1'b0, 1'b0, 1'b1);
        check({7'h00, store_ready}, 8'h00);
        check(words, 8'h03);
        parallel_ready <= 1'b1;
        repeat (4) @(posedge clk);
        check(words, 8'h05);
        check(parallel_out, 8'h95);
        $display("test_stall done");
    endtask
    task automatic test_clears;
        sipo_host_model_inst.set_clears(1'b0, 1'b1);
        repeat (5) @(posedge clk);
        sipo_host_model_inst.pulse(1'b1, 1'b1, 1'b0);
        check({7'h00, cascade_out}, 8'h00);
        check(parallel_out, 8'h95);
        sipo_host_model_inst.set_clears(1'b0, 1'b0);
        repeat (5) @(posedge clk);
        check(parallel_out, 8'h00);
        sipo_host_model_inst.set_clears(1'b1, 1'b1);
        repeat (4) @(posedge clk);
        sipo_host_model_inst.pulse(1'b1, 1'b1, 1'b0);
        sipo_host_model_inst.pulse(1'b0, 1'b0, 1'b1);
        check(parallel_out, 8'h01);
        $display("test_clears done");
    endtask
    task automatic end_sim;
        $display("compared %0d, mismatched %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        rst_n = 1'b0;
        parallel_ready = 1'b1;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        test_load();
        test_tied();
        test_stall();
        test_clears();
        end_sim();
    end
endmodule
